// *** ttic_pkg.sv ***
package ttic_pkg;
    // Register byte addresses
    localparam logic [7:0] OFS_EXT_FLAGS  = 8'h91;
    localparam logic [7:0] OFS_AUX_PRIO   = 8'hA5;
    localparam logic [7:0] OFS_AUX_ENFL   = 8'hA6;
    localparam logic [7:0] OFS_AUX_STAT   = 8'hA7;
    localparam logic [7:0] OFS_IRQ_EN     = 8'hA8;
    localparam logic [7:0] OFS_IRQ_PRIO   = 8'hB8;
    localparam logic [7:0] OFS_EXT_CTRL   = 8'hD8;
    localparam logic [7:0] OFS_EXT_EN     = 8'hE8;
    localparam logic [7:0] OFS_EXT_PRIO   = 8'hF8;
    localparam logic [7:0] OFS_POWER_DOWN = 8'hF1;
    localparam logic [7:0] OFS_HW_CONFIG  = 8'hC0;
    localparam logic [7:0] OFS_BP_CTRL    = 8'hC8;
    localparam logic [7:0] OFS_CORE_FLAGS = 8'hCC;
    localparam logic [7:0] OFS_SER_FLAGS  = 8'hD0;
    // Aux flag clear strobes (decoded core SFR addresses)
    localparam logic [7:0] OFS_MSEC_INT   = 8'hFA;
    localparam logic [7:0] OFS_CONV_LOW   = 8'hD9;
    localparam logic [7:0] OFS_SUM_BYTE0  = 8'hE2;
    localparam logic [7:0] OFS_SEC_INT    = 8'hF9;
    localparam logic [7:0] OFS_SER_DATA   = 8'h9B;
    // Field positions
    localparam int GLOBAL_EN_BIT  = 7;
    localparam int AUX_GEN_BIT    = 5;
    localparam int AUX_FLAG_BIT   = 4;
    localparam int WDOG_FLAG_BIT  = 3;
    localparam int WDOG_IRQ_BIT   = 3;
    localparam int BP_FLAG_BIT    = 7;
    localparam int BP_EN_BIT      = 0;
    localparam int EXT_FLAG_LSB   = 4;
    // Vectors
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_STEP = 16'h0008;
    localparam logic [15:0] VEC_AUX  = 16'h0033;
    localparam int NUM_STD = 12;
    localparam logic [7:0] RESET_ZERO = 8'h00;
    // Power-down bit guarding aux flags 2-6 (1 = powered down)
    localparam logic [2:0] PD_BIT_SPI  = 3'd0;
    localparam logic [2:0] PD_BIT_MSEC = 3'd1;
    localparam logic [2:0] PD_BIT_CONV = 3'd3;
    localparam logic [2:0] PD_BIT_SUM  = 3'd2;
endpackage : ttic_pkg

// *** ttic_controller.sv ***
// Behaviour
// - Raise only if flag, enables, no equal-priority service
// - Force long call to source vector
// - Return restores level; one instruction gap follows
// - Global enable bit 7 at A8h
// - Default low; priority bits select high
// - High group first; fixed order within group
// - Vectors 03h step 8; timer0 flag auto-clears
// - Software-set flags interrupt like hardware
// - Edge ext0/1 auto-clear; level follows pin
// - Serial rx/tx share vector, enable, priority
// - Ext 2,4 rising, 3,5 falling; flags bits 4-7
// - Watchdog interrupts only when config bit 3 clear
// - Aux group gated by D8h bit 5, not A8h bit 7; common flag (D8h bit 4) requests regardless of own enables
// - Aux events set common flag; software clears/sets
// - Pending register gives lowest pending aux code
// - Status register shows active and enabled aux
// - Aux enable reads return raw flags
// - Individual aux flags not software settable
// - Aux flags 2-6 set only while subsystem powered
// - Aux flags cleared by reads, writes, voltage
// - Breakpoint flag bit 7, enable bit 0, write-1-clear
// - Three nesting levels: low, high, aux
module ttic_controller
    import ttic_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        ext0Pin,
    input  wire logic        ext1Pin,
    input  wire logic [3:0]  ext25Pin,
    input  wire logic        ext0EdgeMode,
    input  wire logic        ext1EdgeMode,
    input  wire logic        timer0Event,
    input  wire logic        timer1Event,
    input  wire logic        timer2Event,
    input  wire logic        serial0RxEvent,
    input  wire logic        serial0TxEvent,
    input  wire logic        serial1RxEvent,
    input  wire logic        serial1TxEvent,
    input  wire logic        watchdogEvent,
    input  wire logic [7:0]  auxEvent,
    input  wire logic        breakpointEvent,
    input  wire logic        digitalVoltageOk,
    input  wire logic        analogVoltageOk,
    input  wire logic        instrBoundary,
    input  wire logic        interruptReturn,
    input  wire logic        sfrRead,
    input  wire logic        sfrWrite,
    input  wire logic [7:0]  sfrAddr,
    output logic             longCallInsertion,
    output logic      [15:0] callVector,
    output logic             watchdogReset,
    output logic      [2:0]  inService
);

    typedef struct packed {
        logic [11:0] stdFlag;
        logic [1:0]  ser0Sub;
        logic [1:0]  ser1Sub;
        logic [7:0]  irqEnable;
        logic [7:0]  irqPriority;
        logic [7:0]  extEnable;
        logic [7:0]  extPriority;
        logic [7:0]  auxFlag;
        logic [7:0]  auxEnable;
        logic        auxGlobal;
        logic        auxCommon;
        logic        bpFlag;
        logic        bpEnable;
        logic [7:0]  powerDown;
        logic [7:0]  hwConfig;
        logic [2:0]  inSvc;
        logic        holdOff;
        logic        callPend;
        logic [15:0] vector;
        logic        wdReset;
        logic [31:0] rdata;
        logic        ack;
        logic [2:0]  s0Sync;
        logic [2:0]  s1Sync;
        logic [11:0] s25Sync;
    } ttic_state_t;

    ttic_state_t stReg;
    ttic_state_t stNext;

    function automatic logic [3:0] firstSet(input logic [11:0] v);
        firstSet = 4'hF;
        for (int i = NUM_STD - 1; i >= 0; i--) begin
            if (v[i]) begin
                firstSet = 4'(i);
            end
        end
    endfunction : firstSet

    function automatic logic [3:0] auxCode(input logic [8:0] v);
        auxCode = 4'h0;
        for (int i = 8; i >= 0; i--) begin
            if (v[i]) begin
                auxCode = (i == 0) ? 4'h1 : 4'(i);
            end
        end
    endfunction : auxCode

    function automatic logic [15:0] vecOf(input logic [3:0] idx);
        vecOf = VEC_BASE + {12'h000, idx} * VEC_STEP;
        if (vecOf >= VEC_AUX) vecOf = vecOf + VEC_STEP;
    endfunction : vecOf

    // ------------------------------------------------------------
    // Derived request logic
    // ------------------------------------------------------------
    logic [11:0] stdEnable;
    logic [11:0] stdPrio;
    logic [11:0] stdReq;
    logic [11:0] hiReq;
    logic [11:0] loReq;
    logic [7:0]  auxActive;
    logic        auxReq;
    logic [3:0]  auxPendCode;
    logic        wrAcc;
    logic        rdAcc;
    logic        e0Edge;
    logic        e1Edge;
    logic [3:0]  e25Edge;
    logic [3:0]  srcHi;
    logic [3:0]  srcLo;

    assign stdEnable = {stReg.extEnable[4:0], stReg.irqEnable[6:0]};
    assign stdPrio   = {stReg.extPriority[4:0], stReg.irqPriority[6:0]};
    assign stdReq    = stReg.stdFlag & stdEnable
                       & {12{stReg.irqEnable[GLOBAL_EN_BIT]}};
    assign hiReq     = stdReq & stdPrio;
    assign loReq     = stdReq & ~stdPrio;
    assign auxActive = stReg.auxFlag & stReg.auxEnable;
    assign auxReq    = stReg.auxGlobal
                       && ((|auxActive) || (stReg.bpFlag && stReg.bpEnable)
                           || stReg.auxCommon);
    assign auxPendCode = auxCode({auxActive, stReg.bpFlag && stReg.bpEnable});
    assign srcHi = firstSet(hiReq);
    assign srcLo = firstSet(loReq);
    assign wrAcc = avs_write && stReg.ack;
    assign rdAcc = avs_read && stReg.ack;
    assign e0Edge = stReg.s0Sync[2] && !stReg.s0Sync[1];
    assign e1Edge = stReg.s1Sync[2] && !stReg.s1Sync[1];
    // Rising for 2 and 4, falling for 3 and 5
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (i % 2 == 0) begin
                e25Edge[i] = !stReg.s25Sync[8 + i] && stReg.s25Sync[4 + i];
            end else begin
                e25Edge[i] = stReg.s25Sync[8 + i] && !stReg.s25Sync[4 + i];
            end
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0]  d;
        logic [11:0] hwSet;
        logic [7:0]  auxSet;
        logic [7:0]  auxClr;
        logic        take;
        d = avs_writedata[7:0];
        hwSet = 12'h000;
        auxSet = 8'h00;
        auxClr = 8'h00;
        take = 1'b0;
        stNext = stReg;
        stNext.ack = (avs_read || avs_write) && !stReg.ack;
        stNext.s0Sync = {stReg.s0Sync[1:0], ext0Pin};
        stNext.s1Sync = {stReg.s1Sync[1:0], ext1Pin};
        stNext.s25Sync = {stReg.s25Sync[7:0], ext25Pin};
        stNext.callPend = 1'b0;
        stNext.wdReset = 1'b0;

        // Software writes first; hardware events override
        if (wrAcc) begin
            unique case (avs_address)
                OFS_IRQ_EN:     stNext.irqEnable = d;
                OFS_IRQ_PRIO:   stNext.irqPriority = d;
                OFS_EXT_EN:     stNext.extEnable = d;
                OFS_EXT_PRIO:   stNext.extPriority = d;
                OFS_AUX_ENFL:   stNext.auxEnable = d;
                OFS_POWER_DOWN: stNext.powerDown = d;
                OFS_HW_CONFIG:  stNext.hwConfig = d;
                OFS_EXT_FLAGS:  stNext.stdFlag[10:7] = d[7:4];
                OFS_EXT_CTRL: begin
                    stNext.auxGlobal = d[AUX_GEN_BIT];
                    stNext.auxCommon = d[AUX_FLAG_BIT];
                    stNext.stdFlag[11] = d[WDOG_FLAG_BIT];
                end
                OFS_BP_CTRL: begin
                    stNext.bpEnable = d[BP_EN_BIT];
                    if (d[BP_FLAG_BIT]) begin
                        stNext.bpFlag = 1'b0;
                    end
                end
                OFS_CORE_FLAGS: begin
                    stNext.stdFlag[0] = d[0];
                    stNext.stdFlag[1] = d[1];
                    stNext.stdFlag[2] = d[2];
                    stNext.stdFlag[3] = d[3];
                    stNext.stdFlag[5] = d[5];
                end
                OFS_SER_FLAGS: begin
                    stNext.ser0Sub = d[1:0];
                    stNext.ser1Sub = d[3:2];
                end
                default: ;
            endcase
        end

        // Aux clears from core SFR accesses and supply recovery
        auxClr[0] = digitalVoltageOk;
        auxClr[1] = analogVoltageOk;
        auxClr[2] = sfrRead && sfrAddr == OFS_SER_DATA;
        auxClr[3] = sfrWrite && sfrAddr == OFS_SER_DATA;
        auxClr[4] = sfrRead && sfrAddr == OFS_MSEC_INT;
        auxClr[5] = sfrRead && sfrAddr == OFS_CONV_LOW;
        auxClr[6] = sfrRead && sfrAddr == OFS_SUM_BYTE0;
        auxClr[7] = sfrRead && sfrAddr == OFS_SEC_INT;
        auxSet = auxEvent;
        auxSet[2] = auxEvent[2] && !stReg.powerDown[PD_BIT_SPI];
        auxSet[3] = auxEvent[3] && !stReg.powerDown[PD_BIT_SPI];
        auxSet[4] = auxEvent[4] && !stReg.powerDown[PD_BIT_MSEC];
        auxSet[5] = auxEvent[5] && !stReg.powerDown[PD_BIT_CONV];
        auxSet[6] = auxEvent[6] && !stReg.powerDown[PD_BIT_SUM];
        stNext.auxFlag = (stReg.auxFlag & ~auxClr) | auxSet;
        if ((|auxSet) || breakpointEvent) begin
            stNext.auxCommon = 1'b1;
        end
        if (breakpointEvent) begin
            stNext.bpFlag = 1'b1;
        end

        // Standard source events
        hwSet[0] = ext0EdgeMode ? e0Edge : 1'b0;
        hwSet[1] = timer0Event;
        hwSet[2] = ext1EdgeMode ? e1Edge : 1'b0;
        hwSet[3] = timer1Event;
        hwSet[5] = timer2Event;
        hwSet[10:7] = e25Edge;
        stNext.ser0Sub = stNext.ser0Sub | {serial0TxEvent, serial0RxEvent};
        stNext.ser1Sub = stNext.ser1Sub | {serial1TxEvent, serial1RxEvent};
        if (watchdogEvent) begin
            if (stReg.hwConfig[WDOG_IRQ_BIT]) begin
                stNext.wdReset = 1'b1;
            end else begin
                hwSet[11] = 1'b1;
            end
        end
        stNext.stdFlag = stNext.stdFlag | hwSet;

        // Vector entry and flag auto-clear
        if (instrBoundary && !stReg.holdOff && !stReg.callPend) begin
            if (auxReq && !stReg.inSvc[2]) begin
                take = 1'b1;
                stNext.vector = VEC_AUX;
                stNext.inSvc[2] = 1'b1;
            end else if (srcHi != 4'hF && !(|stReg.inSvc[2:1])) begin
                take = 1'b1;
                stNext.vector = vecOf(srcHi);
                stNext.inSvc[1] = 1'b1;
                if (srcHi == 4'd1) stNext.stdFlag[1] = hwSet[1];
                if (srcHi == 4'd0 && ext0EdgeMode) stNext.stdFlag[0] = hwSet[0];
                if (srcHi == 4'd2 && ext1EdgeMode) stNext.stdFlag[2] = hwSet[2];
            end else if (srcLo != 4'hF && stReg.inSvc == 3'b000) begin
                take = 1'b1;
                stNext.vector = vecOf(srcLo);
                stNext.inSvc[0] = 1'b1;
                if (srcLo == 4'd1) stNext.stdFlag[1] = hwSet[1];
                if (srcLo == 4'd0 && ext0EdgeMode) stNext.stdFlag[0] = hwSet[0];
                if (srcLo == 4'd2 && ext1EdgeMode) stNext.stdFlag[2] = hwSet[2];
            end
        end
        stNext.callPend = take;

        // Level mode flags follow the pins
        if (!ext0EdgeMode) stNext.stdFlag[0] = !stReg.s0Sync[2];
        if (!ext1EdgeMode) stNext.stdFlag[2] = !stReg.s1Sync[2];
        stNext.stdFlag[4] = |stNext.ser0Sub;
        stNext.stdFlag[6] = |stNext.ser1Sub;

        // Return: drop highest level, then hold off one instruction
        if (interruptReturn) begin
            if (stReg.inSvc[2]) stNext.inSvc[2] = 1'b0;
            else if (stReg.inSvc[1]) stNext.inSvc[1] = 1'b0;
            else stNext.inSvc[0] = 1'b0;
            stNext.holdOff = 1'b1;
        end else if (instrBoundary) begin
            stNext.holdOff = 1'b0;
        end

        // Read data
        stNext.rdata = 32'h0000_0000;
        if (avs_read && !stReg.ack) begin
            unique case (avs_address)
                OFS_IRQ_EN:     stNext.rdata[7:0] = stReg.irqEnable;
                OFS_IRQ_PRIO:   stNext.rdata[7:0] = stReg.irqPriority;
                OFS_EXT_EN:     stNext.rdata[7:0] = stReg.extEnable;
                OFS_EXT_PRIO:   stNext.rdata[7:0] = stReg.extPriority;
                OFS_AUX_ENFL:   stNext.rdata[7:0] = stReg.auxFlag;
                OFS_AUX_PRIO:   stNext.rdata[7:0] = {4'h0, auxPendCode};
                OFS_AUX_STAT:   stNext.rdata[7:0] = auxActive;
                OFS_POWER_DOWN: stNext.rdata[7:0] = stReg.powerDown;
                OFS_HW_CONFIG:  stNext.rdata[7:0] = stReg.hwConfig;
                OFS_EXT_FLAGS:  stNext.rdata[7:0] = {stReg.stdFlag[10:7], 4'h0};
                OFS_EXT_CTRL:   stNext.rdata[7:0] = {2'b00, stReg.auxGlobal,
                                    stReg.auxCommon, stReg.stdFlag[11], 3'b000};
                OFS_BP_CTRL:    stNext.rdata[7:0] = {stReg.bpFlag, 6'h00,
                                    stReg.bpEnable};
                OFS_CORE_FLAGS: stNext.rdata[7:0] = {2'b00, stReg.stdFlag[5],
                                    1'b0, stReg.stdFlag[3:0]};
                OFS_SER_FLAGS:  stNext.rdata[7:0] = {4'h0, stReg.ser1Sub,
                                    stReg.ser0Sub};
                default:        stNext.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            stReg <= '0;
        end else begin
            stReg <= stNext;
        end
    end

    assign avs_waitrequest   = (avs_read || avs_write) && !stReg.ack;
    assign avs_readdata      = stReg.rdata;
    assign longCallInsertion = stReg.callPend;
    assign callVector        = stReg.vector;
    assign watchdogReset     = stReg.wdReset;
    assign inService         = stReg.inSvc;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_call_marks_service: assert property (@(posedge clock) disable iff (rst)
        longCallInsertion |-> inService != 3'b000)
        else $error("Call without in-service level");
    a_aux_vector_fixed: assert property (@(posedge clock) disable iff (rst)
        longCallInsertion && $rose(inService[2]) |-> callVector == VEC_AUX)
        else $error("Aux entry used wrong vector");
    a_gap_after_return: assert property (@(posedge clock) disable iff (rst)
        interruptReturn |=> !longCallInsertion)
        else $error("Call right after return");
    a_no_call_global_off: assert property (@(posedge clock) disable iff (rst)
        $rose(inService[0]) |-> $past(stReg.irqEnable[GLOBAL_EN_BIT]))
        else $error("Low entry with global enable off");
    a_wait_one_cycle: assert property (@(posedge clock) disable iff (rst)
        $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("Bus answer not after one cycle");
    a_wdog_reset_gate: assert property (@(posedge clock) disable iff (rst)
        watchdogReset |-> $past(stReg.hwConfig[WDOG_IRQ_BIT]))
        else $error("Watchdog reset while interrupt mode");
    a_low_needs_idle: assert property (@(posedge clock) disable iff (rst)
        $rose(inService[0]) |-> $past(inService) == 3'b000)
        else $error("Low entry while serving");
    a_aux_common_set: assert property (@(posedge clock) disable iff (rst)
        breakpointEvent |=> stReg.auxCommon && stReg.bpFlag)
        else $error("Breakpoint did not set flags");

endmodule : ttic_controller

// *** ttic_core_model.sv ***
module ttic_core_model
    import ttic_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic returnReq,
    output logic      instrBoundary,
    output logic      interruptReturn
);
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [1:0] phase;
        logic       retPending;
        logic       boundary;
        logic       retPulse;
    } ttic_core_t;

    ttic_core_t core_reg;
    ttic_core_t core_next;

    // ------------------------------------------------------------
    // Instruction sequencer
    // ------------------------------------------------------------
    always_comb begin
        core_next = core_reg;
        core_next.phase = core_reg.phase + 2'd1;
        // Boundary every fourth cycle, registered from phase 3 so it is high while phase is 0
        core_next.boundary = (core_reg.phase == 2'd3);
        core_next.retPulse = core_reg.retPending && (core_reg.phase == 2'd1);
        core_next.retPending = returnReq
            || (core_reg.retPending && core_reg.phase != 2'd1);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            core_reg <= '0;
        end else begin
            core_reg <= core_next;
        end
    end

    assign instrBoundary   = core_reg.boundary;
    assign interruptReturn = core_reg.retPulse;
endmodule : ttic_core_model

// *** two_tier_interrupt_controller_test.sv ***
`define CHK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("unexpected at %0t: got %h expected %h", \
                     $time, (got), (exp)); \
        end \
    end

module two_tier_interrupt_controller_test
    import ttic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock = 1'b0;
    logic        rst, avs_read, avs_write, avs_waitrequest;
    logic [7:0]  avs_address, auxEvent, sfrAddr, rdData;
    logic [31:0] avs_writedata, avs_readdata;
    logic        ext0Pin, timer0Event, timer1Event, timer2Event;
    logic        bpEvent, ext0Mode;
    logic [3:0]  ext25Pin;
    logic        serial0RxEvent, serial0TxEvent, serial1RxEvent;
    logic        serial1TxEvent, watchdogEvent, sfrRead, returnReq;
    logic        digitalVoltageOk, analogVoltageOk;
    logic        instrBoundary, interruptReturn;
    logic        longCallInsertion, watchdogReset;
    logic [15:0] callVector;
    logic [2:0]  inService;
    int          bad_count, samples_checked;

    ttic_controller dut (
        .clock(clock), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext0Pin(ext0Pin),
        .ext1Pin(1'b1), .ext25Pin(ext25Pin), .ext0EdgeMode(ext0Mode),
        .ext1EdgeMode(1'b1), .timer0Event(timer0Event),
        .timer1Event(timer1Event), .timer2Event(timer2Event),
        .serial0RxEvent(serial0RxEvent), .serial0TxEvent(serial0TxEvent),
        .serial1RxEvent(serial1RxEvent), .serial1TxEvent(serial1TxEvent),
        .watchdogEvent(watchdogEvent), .auxEvent(auxEvent),
        .breakpointEvent(bpEvent), .digitalVoltageOk(digitalVoltageOk),
        .analogVoltageOk(analogVoltageOk), .instrBoundary(instrBoundary),
        .interruptReturn(interruptReturn), .sfrRead(sfrRead),
        .sfrWrite(1'b0), .sfrAddr(sfrAddr),
        .longCallInsertion(longCallInsertion), .callVector(callVector),
        .watchdogReset(watchdogReset), .inService(inService));

    ttic_core_model core (.clock(clock), .rst(rst), .returnReq(returnReq),
        .instrBoundary(instrBoundary), .interruptReturn(interruptReturn));

    always #5 clock = ~clock;

    // ------------------------------------------------------------
    // Bus and sequencer helpers
    // ------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [7:0] wd);
        @(posedge clock);
        avs_address   <= a;
        avs_writedata <= {24'h00_0000, wd};
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        rdData = avs_readdata[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, m, e);
        xfer(1'b0, a, 8'h00);
        `CHK(rdData & m, e)
    endtask : rd

    task automatic expCall(input logic take, input logic [15:0] v);
        int n;
        for (n = 0; n < 30 && longCallInsertion !== 1'b1; n++)
            @(negedge clock);
        `CHK(longCallInsertion, take)
        if (take === 1'b1) `CHK(callVector, v)
    endtask : expCall

    task automatic ret(input logic [2:0] s);
        int n;
        @(posedge clock);
        returnReq <= 1'b1;
        @(posedge clock);
        returnReq <= 1'b0;
        for (n = 0; n < 12 && inService !== s; n++)
            @(negedge clock);
        `CHK(inService, s)
    endtask : ret

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_regs;
        rd(OFS_IRQ_EN, 8'hFF, 8'h00);
        wr(OFS_IRQ_EN, 8'h82);
        rd(OFS_IRQ_EN, 8'hFF, 8'h82);
        rd(OFS_IRQ_PRIO, 8'hFF, 8'h00);
        wr(8'h42, 8'h5A);
        rd(8'h42, 8'hFF, 8'h00);
        wr(OFS_AUX_PRIO, 8'h07);
        rd(OFS_AUX_PRIO, 8'hFF, 8'h00);
        $display("register test done");
    endtask : t_regs

    task t_timer0;
        wr(OFS_IRQ_EN, 8'h02);
        @(posedge clock) timer0Event <= 1'b1;
        @(posedge clock) timer0Event <= 1'b0;
        expCall(1'b0, 16'h0000);
        wr(OFS_IRQ_EN, 8'h82);
        expCall(1'b1, 16'h000B);
        `CHK(inService, 3'b001)
        rd(OFS_CORE_FLAGS, 8'h02, 8'h00);
        ret(3'b000);
        $display("timer test done");
    endtask : t_timer0

    task t_prio;
        wr(OFS_IRQ_EN, 8'h92);
        wr(OFS_IRQ_PRIO, 8'h10);
        @(posedge clock);
        timer0Event    <= 1'b1;
        serial0RxEvent <= 1'b1;
        @(posedge clock);
        timer0Event    <= 1'b0;
        serial0RxEvent <= 1'b0;
        expCall(1'b1, 16'h0023);
        `CHK(inService, 3'b010)
        wr(OFS_SER_FLAGS, 8'h00);
        expCall(1'b0, 16'h0000);
        ret(3'b000);
        expCall(1'b1, 16'h000B);
        ret(3'b000);
        wr(OFS_IRQ_PRIO, 8'h00);
        $display("priority test done");
    endtask : t_prio

    task t_soft;
        wr(OFS_IRQ_EN, 8'hA0);
        wr(OFS_CORE_FLAGS, 8'h20);
        expCall(1'b1, 16'h002B);
        wr(OFS_CORE_FLAGS, 8'h00);
        ret(3'b000);
        $display("software flag test done");
    endtask : t_soft

    task t_nest;
        wr(OFS_EXT_EN, 8'h01);
        wr(OFS_IRQ_EN, 8'h82);
        wr(OFS_IRQ_PRIO, 8'h02);
        wr(OFS_EXT_CTRL, 8'h20);
        wr(OFS_AUX_ENFL, 8'h10);
        @(posedge clock) ext25Pin[0] <= 1'b1;
        expCall(1'b1, 16'h0043);
        @(posedge clock) timer0Event <= 1'b1;
        @(posedge clock) timer0Event <= 1'b0;
        expCall(1'b1, 16'h000B);
        @(posedge clock) auxEvent <= 8'h50;
        @(posedge clock) auxEvent <= 8'h00;
        expCall(1'b1, 16'h0033);
        `CHK(inService, 3'b111)
        rd(OFS_AUX_PRIO, 8'hFF, 8'h05);
        rd(OFS_AUX_STAT, 8'hFF, 8'h10);
        rd(OFS_AUX_ENFL, 8'hFF, 8'h50);
        rd(OFS_EXT_CTRL, 8'h30, 8'h30);
        @(posedge clock);
        sfrRead <= 1'b1;
        sfrAddr <= OFS_MSEC_INT;
        @(posedge clock) sfrAddr <= OFS_SUM_BYTE0;
        @(posedge clock) sfrRead <= 1'b0;
        rd(OFS_AUX_ENFL, 8'hFF, 8'h00);
        wr(OFS_EXT_CTRL, 8'h20);
        ret(3'b011);
        ret(3'b001);
        wr(OFS_EXT_FLAGS, 8'h00);
        ret(3'b000);
        wr(OFS_EXT_CTRL, 8'h30);
        expCall(1'b1, 16'h0033);
        wr(OFS_EXT_CTRL, 8'h00);
        ret(3'b000);
        wr(OFS_POWER_DOWN, 8'h02);
        @(posedge clock) auxEvent <= 8'h10;
        @(posedge clock) auxEvent <= 8'h00;
        rd(OFS_AUX_ENFL, 8'hFF, 8'h00);
        wr(OFS_POWER_DOWN, 8'h00);
        wr(OFS_EXT_CTRL, 8'h20);
        wr(OFS_BP_CTRL, 8'h01);
        @(posedge clock) bpEvent <= 1'b1;
        @(posedge clock) bpEvent <= 1'b0;
        expCall(1'b1, 16'h0033);
        rd(OFS_AUX_PRIO, 8'hFF, 8'h01);
        wr(OFS_BP_CTRL, 8'h81);
        rd(OFS_BP_CTRL, 8'h81, 8'h01);
        wr(OFS_EXT_CTRL, 8'h00);
        ret(3'b000);
        $display("nesting test done");
    endtask : t_nest

    task t_ext0;
        wr(OFS_IRQ_EN, 8'h81);
        @(posedge clock) ext0Pin <= 1'b0;
        expCall(1'b1, 16'h0003);
        rd(OFS_CORE_FLAGS, 8'h01, 8'h00);
        ret(3'b000);
        wr(OFS_IRQ_EN, 8'h00);
        ext0Mode <= 1'b0;
        rd(OFS_CORE_FLAGS, 8'h01, 8'h01);
        ext0Pin <= 1'b1;
        repeat (4) @(posedge clock);
        rd(OFS_CORE_FLAGS, 8'h01, 8'h00);
        $display("external pin test done");
    endtask : t_ext0

    task t_wdog;
        int n;
        wr(OFS_IRQ_EN, 8'h00);
        wr(OFS_HW_CONFIG, 8'h08);
        @(posedge clock) watchdogEvent <= 1'b1;
        @(posedge clock) watchdogEvent <= 1'b0;
        for (n = 0; n < 10 && watchdogReset !== 1'b1; n++)
            @(negedge clock);
        `CHK(watchdogReset, 1'b1)
        wr(OFS_HW_CONFIG, 8'h00);
        wr(OFS_EXT_EN, 8'h10);
        wr(OFS_IRQ_EN, 8'h80);
        @(posedge clock) watchdogEvent <= 1'b1;
        @(posedge clock) watchdogEvent <= 1'b0;
        expCall(1'b1, 16'h0063);
        rd(OFS_EXT_CTRL, 8'h08, 8'h08);
        wr(OFS_EXT_CTRL, 8'h00);
        ret(3'b000);
        $display("watchdog test done");
    endtask : t_wdog

    task summarize;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize

    initial begin : main
        rst = 1'b1;
        {avs_read, avs_write, timer0Event, timer1Event, timer2Event} = '0;
        {serial0RxEvent, serial0TxEvent, serial1RxEvent} = '0;
        {serial1TxEvent, watchdogEvent, sfrRead, returnReq, bpEvent} = '0;
        {avs_address, auxEvent, sfrAddr, ext25Pin} = '0;
        avs_writedata = '0;
        {ext0Pin, ext0Mode, digitalVoltageOk, analogVoltageOk} = 4'hF;
        bad_count = 0;
        samples_checked = 0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_timer0();
        t_prio();
        t_soft();
        t_nest();
        t_ext0();
        t_wdog();
        summarize();
    end

    initial begin : guard
        repeat (20000) @(posedge clock);
        bad_count++;
        summarize();
    end
endmodule : two_tier_interrupt_controller_test
